// ---- hw/rtca_top.sv ----
// clock output pin selection and alarm configuration with an avalon-mm register slave
`timescale 1ns/100ps
module rtca_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sys_rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic half_tick,
  input wire logic second_half,
  input wire logic [15:0] time_min_sec,
  input wire logic [15:0] time_wkd_hr,
  input wire logic [15:0] time_mon_day,
  output logic clock_out_pin,
  output logic foreign_pad_bit,
  output logic irq
);

  // ==========================================================
  // reset synchronisers
  logic [1:0] rst_pipe;
  logic [1:0] next_rst_pipe;
  logic rst_sync_n;
  logic [1:0] sys_pipe;
  logic [1:0] next_sys_pipe;
  logic sys_clear;

  // power-on reset release and other-reset sampling
  // the other reset is a level from outside, so it crosses two flip-flops before use
  always_comb begin
    next_rst_pipe = {rst_pipe[0], 1'b1};
    next_sys_pipe = {sys_pipe[0], sys_rst_n};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= next_rst_pipe;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sys_pipe <= 2'b11;
    end else begin
      sys_pipe <= next_sys_pipe;
    end
  end

  assign rst_sync_n = rst_pipe[1];
  assign sys_clear = ~sys_pipe[1];

  // ==========================================================
  // bus handshake
  logic [4:0] word_addr;
  logic rd_fire;
  logic wr_fire;
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic [15:0] rd_word;

  // one wait cycle, then the access completes with waitrequest low
  assign word_addr = {avs_address[4:2], 2'b00};
  assign rd_fire = avs_read && !avs_waitrequest;
  assign wr_fire = avs_write && !avs_waitrequest;

  // ==========================================================
  // write strobes, one per register; single-lane ones qualified by the byte lane that holds the field, 16-bit ones merged by lane
  logic wr_cal;
  logic wr_pad;
  logic wr_alcfg;
  logic wr_alval;
  logic wr_stat;
  logic wr_mask;

  // completed write at one offset; every strobe below shares this decode
  function automatic logic wr_at(input logic fire, input logic [4:0] addr, input logic [4:0] off);
    return fire && (addr == off);
  endfunction

  // single-bit fields sit in one lane, so a write to the other lane leaves them alone
  assign wr_cal = wr_at(wr_fire, word_addr, rtca_pkg::OFF_CAL_CFG) && avs_byteenable[1];
  assign wr_pad = wr_at(wr_fire, word_addr, rtca_pkg::OFF_PAD_SEL) && avs_byteenable[0];
  assign wr_alcfg = wr_at(wr_fire, word_addr, rtca_pkg::OFF_AL_CFG);
  assign wr_alval = wr_at(wr_fire, word_addr, rtca_pkg::OFF_AL_VAL);
  assign wr_stat = wr_at(wr_fire, word_addr, rtca_pkg::OFF_IRQ_STAT) && avs_byteenable[0];
  assign wr_mask = wr_at(wr_fire, word_addr, rtca_pkg::OFF_IRQ_MASK) && avs_byteenable[0];

  // ==========================================================
  // register state
  logic cal_oe;
  logic next_cal_oe;
  logic pad_sel;
  logic next_pad_sel;
  logic pad_foreign;
  logic next_pad_foreign;
  logic [15:0] al_cfg;
  logic [15:0] next_al_cfg;
  logic [1:0] irq_stat;
  logic [1:0] next_irq_stat;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_mask;
  logic alarm_pulse;
  logic next_alarm_pulse;
  logic next_pin;
  logic next_irq;
  logic alarm_hit;
  logic auto_off;
  logic win_access;
  logic [15:0] al_rd_data;
  logic [15:0] al_w0;
  logic [15:0] al_w1;
  logic [15:0] al_w2;
  logic [1:0] al_ptr;
  logic [1:0] next_al_ptr;
  logic [7:0] al_rpt;

  assign al_ptr = al_cfg[rtca_pkg::AL_PTR_LSB +: 2];
  assign next_al_ptr = next_al_cfg[rtca_pkg::AL_PTR_LSB +: 2];
  assign al_rpt = al_cfg[rtca_pkg::AL_RPT_LSB +: 8];
  assign win_access = (rd_fire || wr_fire) && (word_addr == rtca_pkg::OFF_AL_VAL);

  // alarm event from the unmasked time fields on a half-second tick
  assign alarm_hit = half_tick && al_cfg[rtca_pkg::AL_EN_BIT]
    && rtca_pkg::mask_match(al_cfg[rtca_pkg::AL_MASK_LSB +: 4], ~second_half,
                            al_w0, al_w1, al_w2, time_min_sec, time_wkd_hr, time_mon_day);
  assign auto_off = alarm_hit && (al_rpt == 8'h00) && !al_cfg[rtca_pkg::AL_CHIME_BIT];

  // ==========================================================
  // alarm value window storage
  rtca_alarm_mem u_mem (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .wr_en(wr_alval),
    .wr_idx(al_ptr),
    .wr_data(rtca_pkg::merge16(al_rd_data, avs_writedata, avs_byteenable)),
    .rd_idx(next_al_ptr),
    .rd_data(al_rd_data),
    .word_min_sec(al_w0),
    .word_wkd_hr(al_w1),
    .word_mon_day(al_w2)
  );

  // ==========================================================
  // read mux
  always_comb begin
    rd_word = 16'h0000;
    case (word_addr)
      rtca_pkg::OFF_CAL_CFG: rd_word[rtca_pkg::CAL_OE_BIT] = cal_oe;
      rtca_pkg::OFF_PAD_SEL: begin
        rd_word[rtca_pkg::PAD_SEL_BIT] = pad_sel;
        rd_word[rtca_pkg::PAD_FOREIGN_BIT] = pad_foreign;
      end
      rtca_pkg::OFF_AL_CFG: rd_word = al_cfg;
      rtca_pkg::OFF_AL_VAL: rd_word = al_rd_data;
      rtca_pkg::OFF_IRQ_STAT: rd_word[1:0] = irq_stat;
      rtca_pkg::OFF_IRQ_MASK: rd_word[1:0] = irq_mask;
      default: rd_word = 16'h0000;
    endcase
  end

  // handshake and read data next values
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
    end
    if (avs_read && avs_waitrequest) begin
      next_readdata = {16'h0000, rd_word};
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // ==========================================================
  // power-on-only configuration: output enable and pad select
  always_comb begin
    next_cal_oe = cal_oe;
    next_pad_sel = pad_sel;
    next_pad_foreign = pad_foreign;
    if (wr_cal) begin
      next_cal_oe = avs_writedata[rtca_pkg::CAL_OE_BIT];
    end
    if (wr_pad) begin
      next_pad_sel = avs_writedata[rtca_pkg::PAD_SEL_BIT];
      next_pad_foreign = avs_writedata[rtca_pkg::PAD_FOREIGN_BIT];
    end
  end

  // cleared by power-on reset only, untouched by the other reset
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cal_oe <= 1'b0;
      pad_sel <= 1'b0;
      pad_foreign <= 1'b0;
    end else begin
      cal_oe <= next_cal_oe;
      pad_sel <= next_pad_sel;
      pad_foreign <= next_pad_foreign;
    end
  end

  // ==========================================================
  // alarm configuration: event effects, pointer stepping, then bus write
  always_comb begin
    next_al_cfg = al_cfg;
    if (auto_off) begin
      next_al_cfg[rtca_pkg::AL_EN_BIT] = 1'b0;
    end else if (alarm_hit) begin
      next_al_cfg[rtca_pkg::AL_RPT_LSB +: 8] = 8'(al_rpt - 8'h01);
    end
    if (win_access && (al_ptr != rtca_pkg::PTR_LAST)) begin
      next_al_cfg[rtca_pkg::AL_PTR_LSB +: 2] = 2'(al_ptr - 2'h1);
    end
    if (wr_alcfg) begin
      next_al_cfg = rtca_pkg::merge16(al_cfg, avs_writedata, avs_byteenable);
    end
    if (sys_clear) begin
      next_al_cfg = rtca_pkg::AL_CFG_RST;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      al_cfg <= rtca_pkg::AL_CFG_RST;
    end else begin
      al_cfg <= next_al_cfg;
    end
  end

  // ==========================================================
  // alarm pulse and pin drive
  always_comb begin
    next_alarm_pulse = alarm_pulse;
    if (alarm_hit) begin
      next_alarm_pulse = 1'b1;
    end else if (half_tick) begin
      next_alarm_pulse = 1'b0;
    end
    // the other reset silences the alarm pulse so the pin goes quiet with it when pad_sel selects the alarm pulse
    if (sys_clear) begin
      next_alarm_pulse = 1'b0;
    end
    next_pin = cal_oe && (pad_sel ? second_half : alarm_pulse);
  end

  // the pin leaves a flip-flop so a select change never glitches it
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alarm_pulse <= 1'b0;
      clock_out_pin <= 1'b0;
      foreign_pad_bit <= 1'b0;
    end else begin
      alarm_pulse <= next_alarm_pulse;
      clock_out_pin <= next_pin;
      foreign_pad_bit <= pad_foreign; // passed on, not used here
    end
  end

  // ==========================================================
  // interrupt status and mask
  always_comb begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    if (wr_stat) begin
      next_irq_stat = irq_stat & ~avs_writedata[1:0];
    end
    if (wr_mask) begin
      next_irq_mask = avs_writedata[1:0];
    end
    // a new event wins over a clear in the same cycle
    next_irq_stat[rtca_pkg::IRQ_ALARM_BIT] = next_irq_stat[rtca_pkg::IRQ_ALARM_BIT] | alarm_hit;
    next_irq_stat[rtca_pkg::IRQ_AUTOOFF_BIT] = next_irq_stat[rtca_pkg::IRQ_AUTOOFF_BIT] | auto_off;
    if (sys_clear) begin
      next_irq_stat = rtca_pkg::IRQ_RST;
      next_irq_mask = rtca_pkg::IRQ_RST;
    end
    next_irq = |(irq_stat & irq_mask);
  end

  // level interrupt, one cycle behind status and mask
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_stat <= rtca_pkg::IRQ_RST;
      irq_mask <= rtca_pkg::IRQ_RST;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

endmodule

// ---- hw/rtca_pkg.sv ----
// constants, field layout and helper functions for the clock output and alarm configuration block
package rtca_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [4:0] OFF_CAL_CFG = 5'h00;
  localparam logic [4:0] OFF_PAD_SEL = 5'h04;
  localparam logic [4:0] OFF_AL_CFG = 5'h08;
  localparam logic [4:0] OFF_AL_VAL = 5'h0c;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h14;

  // ==========================================================
  // field positions
  localparam int CAL_OE_BIT = 10;
  localparam int PAD_SEL_BIT = 1;
  localparam int PAD_FOREIGN_BIT = 0;
  localparam int AL_EN_BIT = 15;
  localparam int AL_CHIME_BIT = 14;
  localparam int AL_MASK_LSB = 10;
  localparam int AL_PTR_LSB = 8;
  localparam int AL_RPT_LSB = 0;
  localparam int IRQ_ALARM_BIT = 0;
  localparam int IRQ_AUTOOFF_BIT = 1;

  // ==========================================================
  // reset values and pointer codes
  localparam logic [15:0] AL_CFG_RST = 16'h0000;
  localparam logic [15:0] AL_VAL_RST = 16'h0000;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [1:0] PTR_LAST = 2'h0;
  localparam logic [1:0] PTR_NONE = 2'h3;

  // ==========================================================
  // alarm period mask codes
  localparam logic [3:0] AM_HALF_SEC = 4'h0;
  localparam logic [3:0] AM_SEC = 4'h1;
  localparam logic [3:0] AM_TEN_SEC = 4'h2;
  localparam logic [3:0] AM_MIN = 4'h3;
  localparam logic [3:0] AM_TEN_MIN = 4'h4;
  localparam logic [3:0] AM_HOUR = 4'h5;
  localparam logic [3:0] AM_DAY = 4'h6;
  localparam logic [3:0] AM_WEEK = 4'h7;
  localparam logic [3:0] AM_MONTH = 4'h8;
  localparam logic [3:0] AM_YEAR = 4'h9;

  // ==========================================================
  // byte-lane merge of a bus write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wdata,
                                          input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // alarm match for a mask code; words hold min:sec, weekday:hour, month:day
  function automatic logic mask_match(input logic [3:0] code, input logic new_sec,
                                      input logic [15:0] a0, input logic [15:0] a1,
                                      input logic [15:0] a2, input logic [15:0] t0,
                                      input logic [15:0] t1, input logic [15:0] t2);
    logic m;
    m = 1'b0;
    case (code)
      AM_HALF_SEC: m = 1'b1;
      AM_SEC: m = new_sec;
      AM_TEN_SEC: m = new_sec && (a0[3:0] == t0[3:0]);
      AM_MIN: m = new_sec && (a0[7:0] == t0[7:0]);
      AM_TEN_MIN: m = new_sec && (a0[11:0] == t0[11:0]);
      AM_HOUR: m = new_sec && (a0 == t0);
      AM_DAY: m = new_sec && (a0 == t0) && (a1[7:0] == t1[7:0]);
      AM_WEEK: m = new_sec && (a0 == t0) && (a1 == t1);
      AM_MONTH: m = new_sec && (a0 == t0) && (a1[7:0] == t1[7:0]) && (a2[7:0] == t2[7:0]);
      AM_YEAR: m = new_sec && (a0 == t0) && (a1[7:0] == t1[7:0]) && (a2 == t2);
      default: m = 1'b0;
    endcase
    return m;
  endfunction

endpackage

// ---- hw/rtca_alarm_mem.sv ----
// alarm value storage with one write port, registered read port and live words for matching
`timescale 1ns/100ps
module rtca_alarm_mem (
  input wire logic mclk,
  input wire logic rst_sync_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] rd_idx,
  output logic [15:0] rd_data,
  output logic [15:0] word_min_sec,
  output logic [15:0] word_wkd_hr,
  output logic [15:0] word_mon_day
);

  logic [15:0] mem [0:2];
  logic [15:0] next_mem [0:2];
  logic [15:0] next_rd_data;

  // ==========================================================
  // write and read next values; index 3 holds nothing
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_mem[i] = mem[i];
    end
    if (wr_en && (wr_idx != rtca_pkg::PTR_NONE)) begin
      next_mem[wr_idx] = wr_data;
    end
    next_rd_data = (rd_idx == rtca_pkg::PTR_NONE) ? 16'h0000 : next_mem[rd_idx];
  end

  // storage and read register
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < 3; i++) begin
        mem[i] <= rtca_pkg::AL_VAL_RST;
      end
      rd_data <= rtca_pkg::AL_VAL_RST;
    end else begin
      for (int i = 0; i < 3; i++) begin
        mem[i] <= next_mem[i];
      end
      rd_data <= next_rd_data;
    end
  end

  assign word_min_sec = mem[0];
  assign word_wkd_hr = mem[1];
  assign word_mon_day = mem[2];

endmodule

// ---- tb/rtca_props.sv ----
// concurrent checks on the ports of the clock output and alarm block
`timescale 1ns/100ps
module rtca_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sys_rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic half_tick,
  input wire logic second_half,
  input wire logic clock_out_pin,
  input wire logic foreign_pad_bit,
  input wire logic irq
);
  logic wpad;
  logic rdok;
  // ==========================================================
  // helper terms
  // completed pad select write on lane 0, and a completed read
  assign wpad = avs_write && !avs_waitrequest && avs_address == rtca_pkg::OFF_PAD_SEL && avs_byteenable[0];
  assign rdok = avs_read && !avs_waitrequest;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // assertions
  pad_read_zero_a: assert property (rdok && avs_address == rtca_pkg::OFF_PAD_SEL |-> avs_readdata[15:2] == 14'h0)
    else $error("pad select upper bits not zero");
  read_upper_zero_a: assert property (rdok |-> avs_readdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  wait_one_cycle_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write) ##1 avs_waitrequest)
    else $error("wait low without request or too long");
  foreign_bit_write_a: assert property ($changed(foreign_pad_bit) |-> $past(wpad) || $past(wpad, 2))
    else $error("foreign bit moved without a write");
  pin_rise_cause_a: assert property ($rose(clock_out_pin) |->
    $past(second_half) || $past(half_tick, 2) || $past(avs_write) || $past(avs_write, 2))
    else $error("pin rose without a source");
  pin_fall_cause_a: assert property ($fell(clock_out_pin) |-> !$past(second_half) || $past(half_tick, 2) ||
    $past(avs_write) || $past(avs_write, 2) || !$past(sys_rst_n, 3) || !$past(sys_rst_n, 4))
    else $error("pin fell without a cause");
  irq_rise_cause_a: assert property ($rose(irq) |-> $past(half_tick, 2) || $past(half_tick, 3) ||
    $past(avs_write, 2) || $past(avs_write, 3))
    else $error("irq rose without event or mask write");
  irq_fall_cause_a: assert property ($fell(irq) |-> $past(avs_write, 2) || $past(avs_write, 3) ||
    !$past(sys_rst_n, 3) || !$past(sys_rst_n, 4))
    else $error("irq fell without clear");
endmodule
bind rtca_top rtca_props u_props (.mclk(mclk), .rst_n(rst_n), .sys_rst_n(sys_rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .half_tick(half_tick), .second_half(second_half),
  .clock_out_pin(clock_out_pin), .foreign_pad_bit(foreign_pad_bit), .irq(irq));

// ---- tb/tb.sv ----
// self-checking bench for the clock output and alarm configuration block
`timescale 1ns/100ps
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sys_rst_n = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic half_tick = 1'b0;
  logic second_half = 1'b0;
  logic [47:0] tfld = 48'h0;
  logic clock_out_pin;
  logic foreign_pad_bit;
  logic irq;
  logic [31:0] rd;
  int n_mismatch = 0;
  int total_checks = 0;

  rtca_top dut (.mclk(mclk), .rst_n(rst_n), .sys_rst_n(sys_rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .half_tick(half_tick),
    .second_half(second_half), .time_min_sec(tfld[15:0]), .time_wkd_hr(tfld[31:16]), .time_mon_day(tfld[47:32]),
    .clock_out_pin(clock_out_pin), .foreign_pad_bit(foreign_pad_bit), .irq(irq));

  // ==========================================================
  // clock and run control
  always #20 mclk = ~mclk;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one compare for every value seen at the ports
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // avalon-mm master: hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    // only the watchdog ends a wait that never completes
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    logic [31:0] d;
    bus(1'b1, a, {16'h0, v}, d);
  endtask

  // read and compare against an expected 16-bit value
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, {16'h0, exp});
  endtask

  // one half-second tick and time for the pin and irq to follow
  task automatic tick();
    @(posedge mclk);
    half_tick <= 1'b1;
    @(posedge mclk);
    half_tick <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // time bit to disturb for a period code: one it compares, or one it must ignore
  function automatic int flip_bit(input int c, input logic cmp);
    int b;
    b = 24;
    case (c)
      2: b = cmp ? 0 : 4;
      3: b = cmp ? 4 : 8;
      4: b = cmp ? 8 : 12;
      5: b = cmp ? 12 : 16;
      6: b = cmp ? 16 : 24;
      7: b = cmp ? 24 : 32;
      8: b = cmp ? 32 : 24;
      9: b = cmp ? 40 : 24;
      default: b = 24;
    endcase
    return b;
  endfunction

  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end

  // ==========================================================
  // test sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    // every mapped and unmapped place reads zero after power-on reset
    for (int i = 0; i < 8; i++) begin
      rc(5'(i * 4), 16'h0000);
    end
    wr(rtca_pkg::OFF_PAD_SEL, 16'hffff);
    rc(rtca_pkg::OFF_PAD_SEL, 16'h0003);
    chk({31'h0, foreign_pad_bit}, 32'h1);
    wr(rtca_pkg::OFF_CAL_CFG, 16'hffff);
    rc(rtca_pkg::OFF_CAL_CFG, 16'h0400);
    // seconds clock on the pin
    second_half <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({31'h0, clock_out_pin}, 32'h1);
    second_half <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({31'h0, clock_out_pin}, 32'h0);
    // other reset leaves output enable and pad select alone, clears alarm configuration
    wr(rtca_pkg::OFF_AL_CFG, 16'h0005);
    sys_rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    sys_rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rc(rtca_pkg::OFF_CAL_CFG, 16'h0400);
    rc(rtca_pkg::OFF_PAD_SEL, 16'h0003);
    rc(rtca_pkg::OFF_AL_CFG, 16'h0000);
    // window pointer steps down to zero and stays there
    wr(rtca_pkg::OFF_AL_CFG, 16'h0200);
    wr(rtca_pkg::OFF_AL_VAL, 16'h1234);
    wr(rtca_pkg::OFF_AL_VAL, 16'h5678);
    rc(rtca_pkg::OFF_AL_CFG, 16'h0000);
    wr(rtca_pkg::OFF_AL_VAL, 16'h9abc);
    rc(rtca_pkg::OFF_AL_CFG, 16'h0000);
    wr(rtca_pkg::OFF_AL_CFG, 16'h0200);
    rc(rtca_pkg::OFF_AL_VAL, 16'h1234);
    rc(rtca_pkg::OFF_AL_VAL, 16'h5678);
    rc(rtca_pkg::OFF_AL_VAL, 16'h9abc);
    // pointer 3 selects no word: reads zero, writes are dropped, pointer still steps
    wr(rtca_pkg::OFF_AL_CFG, 16'h0300);
    rc(rtca_pkg::OFF_AL_VAL, 16'h0000);
    wr(rtca_pkg::OFF_AL_CFG, 16'h0300);
    wr(rtca_pkg::OFF_AL_VAL, 16'hffff);
    rc(rtca_pkg::OFF_AL_VAL, 16'h1234);
    rc(rtca_pkg::OFF_AL_CFG, 16'h0100);
    // alarm pulse on the pin, repeat count down, then auto disable
    wr(rtca_pkg::OFF_PAD_SEL, 16'h0000);
    wr(rtca_pkg::OFF_IRQ_MASK, 16'h0003);
    wr(rtca_pkg::OFF_AL_CFG, 16'h8001);
    tick();
    rc(rtca_pkg::OFF_AL_CFG, 16'h8000);
    chk({31'h0, clock_out_pin}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    tick();
    rc(rtca_pkg::OFF_AL_CFG, 16'h0000);
    rc(rtca_pkg::OFF_IRQ_STAT, 16'h0003);
    tick();
    chk({31'h0, clock_out_pin}, 32'h0);
    // mask, unmask and clear the interrupt
    wr(rtca_pkg::OFF_IRQ_MASK, 16'h0000);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(rtca_pkg::OFF_IRQ_MASK, 16'h0002);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    wr(rtca_pkg::OFF_IRQ_STAT, 16'h0003);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rc(rtca_pkg::OFF_IRQ_STAT, 16'h0000);
    // chime lets the count roll over
    wr(rtca_pkg::OFF_AL_CFG, 16'hc000);
    tick();
    rc(rtca_pkg::OFF_AL_CFG, 16'hc0ff);
    // reserved mask codes never fire, a real code does at the second
    wr(rtca_pkg::OFF_AL_CFG, 16'ha800);
    tick();
    rc(rtca_pkg::OFF_AL_CFG, 16'ha800);
    wr(rtca_pkg::OFF_AL_CFG, 16'hb002);
    tick();
    rc(rtca_pkg::OFF_AL_CFG, 16'hb002);
    wr(rtca_pkg::OFF_AL_CFG, 16'h8402);
    tick();
    rc(rtca_pkg::OFF_AL_CFG, 16'h8401);
    // the second code needs the start of a second
    second_half <= 1'b1;
    wr(rtca_pkg::OFF_AL_CFG, 16'h8402);
    tick();
    rc(rtca_pkg::OFF_AL_CFG, 16'h8402);
    second_half <= 1'b0;
    // each period code from 2 to 9 compares exactly its own time fields: match, ignored bit, compared bit
    for (int c = 2; c < 10; c++) begin
      for (int k = 0; k < 3; k++) begin
        tfld <= 48'h1234_5678_9abc ^ ((k == 0) ? 48'h0 : (48'h1 << flip_bit(c, k == 2)));
        wr(rtca_pkg::OFF_AL_CFG, 16'(32'h8002 | (c << 10)));
        tick();
        rc(rtca_pkg::OFF_AL_CFG, 16'(32'h8000 | (c << 10) | ((k == 2) ? 2 : 1)));
      end
    end
    // a write on lane 0 alone leaves the upper byte as it was
    avs_byteenable <= 4'h1;
    wr(rtca_pkg::OFF_AL_CFG, 16'h00ff);
    rc(rtca_pkg::OFF_AL_CFG, 16'ha4ff);
    avs_byteenable <= 4'hf;
    complete_run();
  end
endmodule
